// ===== coc_pkg.sv
// Operation
// - saturation clamps results above 7FFFFFFF and below 80000000 to those limits
// - first register field selects the general register read as source
// - second register field selects the result register, sometimes also a source
// - third register field receives division remainder or upper product word
// - bit operations use a three-bit field picking bit 0 to 7
// - trap carries a five-bit vector, every value 00 to 1F accepted
// - conditional branch evaluates a four-bit condition field against the flags
// - register 30 is the element pointer, base of short-format accesses
// - zero extension fills all upper bits with zeros to 32 bits
// - sign extension copies the top bit into all upper bits
// - bit store changes only the selected bit of the addressed byte
// - a system register number field selects the transferred system register
// - taken branch adds sign-extended nine-bit displacement, else continue sequentially
package coc_pkg;
	localparam int unsigned GPR_NUM    = 32;
	localparam int unsigned SYSREG_NUM = 32;
	localparam int unsigned REG_FIELD_W = 5;
	localparam int unsigned SYSREG_W   = 5;
	localparam int unsigned BIT_NUM_W  = 3;
	localparam int unsigned VEC_W      = 5;
	localparam int unsigned COND_W     = 4;
	localparam int unsigned BRANCH_DISPLACEMENT_W    = 9;
	localparam int unsigned IMM16_W    = 16;
	localparam int unsigned BYTE_W     = 8;
	localparam int unsigned HALF_W     = 16;
	localparam int unsigned WORD_W     = 32;
	localparam int unsigned LEN_W      = 3;

	localparam logic [4:0]  ZERO_IDX = 5'h00;
	localparam logic [4:0]  SP_IDX   = 5'h03;
	localparam logic [4:0]  EP_IDX   = 5'h1E;

	localparam logic [31:0] SAT_MAX  = 32'h7FFFFFFF;
	localparam logic [31:0] SAT_MIN  = 32'h80000000;
	localparam logic [31:0] PC_RESET = 32'h00000000;
	localparam logic [31:0] TRAP_BASE = 32'h00000040;
	localparam int unsigned VEC_SHIFT = 4;

	localparam int unsigned FLAGS_W = 5;
	localparam int unsigned FLG_Z   = 0;
	localparam int unsigned FLG_S   = 1;
	localparam int unsigned FLG_OV  = 2;
	localparam int unsigned FLG_CY  = 3;
	localparam int unsigned FLG_SAT = 4;

	localparam logic [3:0] CC_V   = 4'h0;
	localparam logic [3:0] CC_NV  = 4'h8;
	localparam logic [3:0] CC_C   = 4'h1;
	localparam logic [3:0] CC_NC  = 4'h9;
	localparam logic [3:0] CC_Z   = 4'h2;
	localparam logic [3:0] CC_NZ  = 4'hA;
	localparam logic [3:0] CC_NH  = 4'h3;
	localparam logic [3:0] CC_H   = 4'hB;
	localparam logic [3:0] CC_N   = 4'h4;
	localparam logic [3:0] CC_P   = 4'hC;
	localparam logic [3:0] CC_T   = 4'h5;
	localparam logic [3:0] CC_SA  = 4'hD;
	localparam logic [3:0] CC_LT  = 4'h6;
	localparam logic [3:0] CC_GE  = 4'hE;
	localparam logic [3:0] CC_LE  = 4'h7;
	localparam logic [3:0] CC_GT  = 4'hF;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_HALF = 2'h1,
		SZ_WORD = 2'h2
	} coc_size_t;

	typedef enum logic [4:0] {
		OP_NOP    = 5'h00,
		OP_ADD    = 5'h01,
		OP_ADDI   = 5'h02,
		OP_ANDI   = 5'h03,
		OP_SATADD = 5'h04,
		OP_MUL    = 5'h05,
		OP_DIV    = 5'h06,
		OP_LD     = 5'h07,
		OP_ST     = 5'h08,
		OP_LD_EP  = 5'h09,
		OP_ST_EP  = 5'h0A,
		OP_LD_SP  = 5'h0B,
		OP_ST_SP  = 5'h0C,
		OP_BIT_ST = 5'h0D,
		OP_TRAP   = 5'h0E,
		OP_BCOND  = 5'h0F,
		OP_LDSR   = 5'h10,
		OP_STSR   = 5'h11
	} coc_op_t;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'h1,
		ST_MEM    = 4'h2,
		ST_RMW_RD = 4'h4,
		ST_RMW_WR = 4'h8
	} coc_state_t;
endpackage

// ===== coc_ext_sat.sv
`timescale 1ns/1ps
`default_nettype none
module coc_ext_sat (
	input  wire logic [31:0]       data_i,
	input  wire coc_pkg::coc_size_t size_i,
	input  wire logic              sign_i,
	output logic      [31:0]       ext_o,
	input  wire logic [63:0]       wide_i,
	output logic      [31:0]       sat_o,
	output logic                   sat_hit_o
);
	logic [32:0] top_bits;

	always_comb begin
		case (size_i)
			coc_pkg::SZ_BYTE: begin
				ext_o = sign_i ? {{(coc_pkg::WORD_W - coc_pkg::BYTE_W){data_i[7]}}, data_i[7:0]}
					: {{(coc_pkg::WORD_W - coc_pkg::BYTE_W){1'b0}}, data_i[7:0]};
			end
			coc_pkg::SZ_HALF: begin
				ext_o = sign_i ? {{(coc_pkg::WORD_W - coc_pkg::HALF_W){data_i[15]}}, data_i[15:0]}
					: {{(coc_pkg::WORD_W - coc_pkg::HALF_W){1'b0}}, data_i[15:0]};
			end
			default: begin
				ext_o = data_i;
			end
		endcase
	end

	// clamp when the upper 33 bits are not all equal
	assign top_bits  = wide_i[63:31];
	assign sat_hit_o = (top_bits != {33{1'b0}}) && (top_bits != {33{1'b1}});
	assign sat_o     = !sat_hit_o ? wide_i[31:0]
		: (wide_i[63] ? coc_pkg::SAT_MIN : coc_pkg::SAT_MAX);
endmodule
`default_nettype wire

// ===== coc_core.sv
`timescale 1ns/1ps
`default_nettype none
module coc_core (
	input  wire logic                    clk_sys_i,
	input  wire logic                    rst_n_i,
	input  wire logic                    ce_i,
	input  wire logic                    op_valid_i,
	output logic                         op_ready_o,
	input  wire coc_pkg::coc_op_t        op_code_i,
	input  wire logic [4:0]              source_reg_field_i,
	input  wire logic [4:0]              dest_reg_field_i,
	input  wire logic [4:0]              aux_result_reg_field_i,
	input  wire logic [4:0]              system_reg_number_i,
	input  wire logic [2:0]              bit_number_i,
	input  wire logic                    bit_value_i,
	input  wire logic [4:0]              trap_vector_i,
	input  wire logic [3:0]              cond_code_i,
	input  wire logic [8:0]              branch_displacement_i,
	input  wire logic [15:0]             imm16_i,
	input  wire coc_pkg::coc_size_t      mem_size_i,
	input  wire logic                    mem_sign_i,
	input  wire logic [2:0]              instr_len_i,
	output logic                         mem_req_o,
	output logic                         mem_we_o,
	output logic      [31:0]             mem_addr_o,
	output coc_pkg::coc_size_t           mem_size_o,
	output logic      [31:0]             mem_wdata_o,
	input  wire logic [31:0]             mem_rdata_i,
	input  wire logic                    mem_ack_i,
	output logic      [31:0]             pc_o,
	output logic      [4:0]              flags_o,
	output logic                         trap_o,
	output logic      [4:0]              trap_vector_o,
	input  wire logic [4:0]              dbg_reg_idx_i,
	output logic      [31:0]             dbg_reg_data_o
);
	coc_pkg::coc_state_t state_ff;
	logic [31:0]         gpr_ff [coc_pkg::GPR_NUM];
	logic [31:0]         sysreg_ff [coc_pkg::SYSREG_NUM];
	logic [31:0]         pc_ff, nxt_pc;
	logic [4:0]          flags_ff, nxt_flags;
	logic                trap_ff;
	logic [4:0]          trap_vector_ff;
	logic [31:0]         dbg_ff;
	logic                req_ff, we_ff, sign_ff, bitval_ff;
	logic [31:0]         addr_ff, wdata_ff;
	coc_pkg::coc_size_t  size_ff;
	logic [4:0]          dst_ff;
	logic [2:0]          bit_ff;

	logic                accept, load_done, rmw_rd_done;
	logic                is_mem, is_bit;
	logic [31:0]         src_val, dst_val, imm_ext, load_ext, sat_val, base, disp_ext;
	logic                sat_hit, imm_sign, ex_we, aux_we, cond_ok;
	logic [31:0]         ex_wdata, aux_wdata;
	logic [32:0]         sum;
	logic [63:0]         wide_sum, prod;
	logic [7:0]          byte_mod;
	logic                wr_en;
	logic [4:0]          wr_idx;
	logic [31:0]         wr_data;

	assign src_val  = gpr_ff[source_reg_field_i];
	assign dst_val  = gpr_ff[dest_reg_field_i];
	assign imm_sign = (op_code_i != coc_pkg::OP_ANDI);
	assign wide_sum = {{32{dst_val[31]}}, dst_val} + {{32{src_val[31]}}, src_val};
	assign disp_ext = {{(coc_pkg::WORD_W - coc_pkg::BRANCH_DISPLACEMENT_W){branch_displacement_i[8]}},
		branch_displacement_i};

	coc_ext_sat u_ext_imm (
		.data_i    ({16'h0000, imm16_i}),
		.size_i    (coc_pkg::SZ_HALF),
		.sign_i    (imm_sign),
		.ext_o     (imm_ext),
		.wide_i    (wide_sum),
		.sat_o     (sat_val),
		.sat_hit_o (sat_hit)
	);

	coc_ext_sat u_ext_load (
		.data_i    (mem_rdata_i),
		.size_i    (size_ff),
		.sign_i    (sign_ff),
		.ext_o     (load_ext),
		.wide_i    (64'h0000000000000000),
		.sat_o     (),
		.sat_hit_o ()
	);

	function automatic logic cond_eval(input logic [3:0] cc, input logic [4:0] f);
		logic z, s, ov, cy;
		z  = f[coc_pkg::FLG_Z];
		s  = f[coc_pkg::FLG_S];
		ov = f[coc_pkg::FLG_OV];
		cy = f[coc_pkg::FLG_CY];
		case (cc)
			coc_pkg::CC_V:  cond_eval = ov;
			coc_pkg::CC_NV: cond_eval = !ov;
			coc_pkg::CC_C:  cond_eval = cy;
			coc_pkg::CC_NC: cond_eval = !cy;
			coc_pkg::CC_Z:  cond_eval = z;
			coc_pkg::CC_NZ: cond_eval = !z;
			coc_pkg::CC_NH: cond_eval = cy | z;
			coc_pkg::CC_H:  cond_eval = !(cy | z);
			coc_pkg::CC_N:  cond_eval = s;
			coc_pkg::CC_P:  cond_eval = !s;
			coc_pkg::CC_T:  cond_eval = 1'b1;
			coc_pkg::CC_SA: cond_eval = f[coc_pkg::FLG_SAT];
			coc_pkg::CC_LT: cond_eval = s ^ ov;
			coc_pkg::CC_GE: cond_eval = !(s ^ ov);
			coc_pkg::CC_LE: cond_eval = (s ^ ov) | z;
			default:        cond_eval = !((s ^ ov) | z);
		endcase
	endfunction

	assign cond_ok    = cond_eval(cond_code_i, flags_ff);
	assign op_ready_o = (state_ff == coc_pkg::ST_IDLE);
	assign accept     = ce_i & op_valid_i & op_ready_o;
	assign is_bit     = (op_code_i == coc_pkg::OP_BIT_ST);
	assign is_mem     = (op_code_i == coc_pkg::OP_LD) || (op_code_i == coc_pkg::OP_ST)
		|| (op_code_i == coc_pkg::OP_LD_EP) || (op_code_i == coc_pkg::OP_ST_EP)
		|| (op_code_i == coc_pkg::OP_LD_SP) || (op_code_i == coc_pkg::OP_ST_SP);
	assign load_done  = ce_i & mem_ack_i & !we_ff & (state_ff == coc_pkg::ST_MEM);
	assign rmw_rd_done = ce_i & mem_ack_i & (state_ff == coc_pkg::ST_RMW_RD);

	// address base selection
	always_comb begin
		case (op_code_i)
			coc_pkg::OP_LD_EP, coc_pkg::OP_ST_EP: base = gpr_ff[coc_pkg::EP_IDX];
			coc_pkg::OP_LD_SP, coc_pkg::OP_ST_SP: base = gpr_ff[coc_pkg::SP_IDX];
			default:                              base = src_val;
		endcase
	end

	// execute stage for register operations
	always_comb begin
		sum       = {1'b0, dst_val} + {1'b0, src_val};
		prod      = 64'($signed(dst_val) * $signed(src_val));
		ex_we     = 1'b0;
		ex_wdata  = 32'h00000000;
		aux_we    = 1'b0;
		aux_wdata = 32'h00000000;
		nxt_flags = flags_ff;
		nxt_pc    = pc_ff + {29'h00000000, instr_len_i};
		case (op_code_i)
			coc_pkg::OP_ADD, coc_pkg::OP_ADDI: begin
				if (op_code_i == coc_pkg::OP_ADDI) begin
					sum = {1'b0, src_val} + {1'b0, imm_ext};
				end
				ex_we    = 1'b1;
				ex_wdata = sum[31:0];
				nxt_flags[coc_pkg::FLG_CY] = sum[32];
				nxt_flags[coc_pkg::FLG_OV] = (op_code_i == coc_pkg::OP_ADD)
					? (dst_val[31] == src_val[31]) && (sum[31] != dst_val[31])
					: (src_val[31] == imm_ext[31]) && (sum[31] != src_val[31]);
				nxt_flags[coc_pkg::FLG_S]  = sum[31];
				nxt_flags[coc_pkg::FLG_Z]  = (sum[31:0] == 32'h00000000);
			end
			coc_pkg::OP_ANDI: begin
				ex_we    = 1'b1;
				ex_wdata = src_val & imm_ext;
				nxt_flags[coc_pkg::FLG_OV] = 1'b0;
				nxt_flags[coc_pkg::FLG_S]  = ex_wdata[31];
				nxt_flags[coc_pkg::FLG_Z]  = (ex_wdata == 32'h00000000);
			end
			coc_pkg::OP_SATADD: begin
				ex_we    = 1'b1;
				ex_wdata = sat_val;
				nxt_flags[coc_pkg::FLG_CY] = sum[32];
				nxt_flags[coc_pkg::FLG_OV] = sat_hit;
				nxt_flags[coc_pkg::FLG_S]  = sat_val[31];
				nxt_flags[coc_pkg::FLG_Z]  = (sat_val == 32'h00000000);
				nxt_flags[coc_pkg::FLG_SAT] = flags_ff[coc_pkg::FLG_SAT] | sat_hit;
			end
			coc_pkg::OP_MUL: begin
				ex_we     = 1'b1;
				ex_wdata  = prod[31:0];
				aux_we    = 1'b1;
				aux_wdata = prod[63:32];
			end
			coc_pkg::OP_DIV: begin
				if (src_val != 32'h00000000) begin
					ex_we     = 1'b1;
					ex_wdata  = 32'($signed(dst_val) / $signed(src_val));
					aux_we    = 1'b1;
					aux_wdata = 32'($signed(dst_val) % $signed(src_val));
					nxt_flags[coc_pkg::FLG_OV] = 1'b0;
				end else begin
					nxt_flags[coc_pkg::FLG_OV] = 1'b1;
				end
			end
			coc_pkg::OP_BCOND: begin
				if (cond_ok) begin
					nxt_pc = pc_ff + disp_ext;
				end
			end
			coc_pkg::OP_TRAP: begin
				nxt_pc = coc_pkg::TRAP_BASE
					+ ({27'h0000000, trap_vector_i} << coc_pkg::VEC_SHIFT);
			end
			coc_pkg::OP_STSR: begin
				ex_we    = 1'b1;
				ex_wdata = sysreg_ff[system_reg_number_i];
			end
			default: begin
				ex_we = 1'b0;
			end
		endcase
	end

	assign wr_en   = (accept & ex_we) | load_done;
	assign wr_idx  = load_done ? dst_ff : dest_reg_field_i;
	assign wr_data = load_done ? load_ext : ex_wdata;

	// general registers, entry zero reads as zero
	for (genvar g = 0; g < coc_pkg::GPR_NUM; g++) begin : g_gpr
		always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				gpr_ff[g] <= 32'h00000000;
			end else if ((g != 0) && wr_en && (wr_idx == 5'(g))) begin
				gpr_ff[g] <= wr_data;
			end else if ((g != 0) && accept && aux_we && (aux_result_reg_field_i == 5'(g))) begin
				gpr_ff[g] <= aux_wdata;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < coc_pkg::SYSREG_NUM; i++) begin
				sysreg_ff[i] <= 32'h00000000;
			end
		end else if (accept && (op_code_i == coc_pkg::OP_LDSR)) begin
			sysreg_ff[system_reg_number_i] <= src_val;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pc_ff          <= coc_pkg::PC_RESET;
			flags_ff       <= 5'h00;
			trap_ff        <= 1'b0;
			trap_vector_ff <= 5'h00;
			dbg_ff         <= 32'h00000000;
		end else if (ce_i) begin
			dbg_ff  <= gpr_ff[dbg_reg_idx_i];
			trap_ff <= accept && (op_code_i == coc_pkg::OP_TRAP);
			if (accept) begin
				pc_ff    <= nxt_pc;
				flags_ff <= nxt_flags;
				if (op_code_i == coc_pkg::OP_TRAP) begin
					trap_vector_ff <= trap_vector_i;
				end
			end else if (rmw_rd_done) begin
				flags_ff[coc_pkg::FLG_Z] <= !mem_rdata_i[bit_ff];
			end
		end
	end

	// modify one bit of the fetched byte
	always_comb begin
		byte_mod         = mem_rdata_i[7:0];
		byte_mod[bit_ff] = bitval_ff;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff  <= coc_pkg::ST_IDLE;
			req_ff    <= 1'b0;
			we_ff     <= 1'b0;
			addr_ff   <= 32'h00000000;
			wdata_ff  <= 32'h00000000;
			size_ff   <= coc_pkg::SZ_WORD;
			sign_ff   <= 1'b0;
			dst_ff    <= 5'h00;
			bit_ff    <= 3'h0;
			bitval_ff <= 1'b0;
		end else if (ce_i) begin
			case (state_ff)
				coc_pkg::ST_IDLE: begin
					if (accept && (is_mem || is_bit)) begin
						req_ff    <= 1'b1;
						addr_ff   <= base + imm_ext;
						dst_ff    <= dest_reg_field_i;
						sign_ff   <= mem_sign_i;
						bit_ff    <= bit_number_i;
						bitval_ff <= bit_value_i;
						wdata_ff  <= dst_val;
						size_ff   <= is_bit ? coc_pkg::SZ_BYTE : mem_size_i;
						we_ff     <= (op_code_i == coc_pkg::OP_ST)
							|| (op_code_i == coc_pkg::OP_ST_EP)
							|| (op_code_i == coc_pkg::OP_ST_SP);
						state_ff  <= is_bit ? coc_pkg::ST_RMW_RD : coc_pkg::ST_MEM;
					end
				end
				coc_pkg::ST_MEM, coc_pkg::ST_RMW_WR: begin
					if (mem_ack_i) begin
						req_ff   <= 1'b0;
						we_ff    <= 1'b0;
						state_ff <= coc_pkg::ST_IDLE;
					end
				end
				coc_pkg::ST_RMW_RD: begin
					if (mem_ack_i) begin
						we_ff    <= 1'b1;
						wdata_ff <= {24'h000000, byte_mod};
						state_ff <= coc_pkg::ST_RMW_WR;
					end
				end
				default: begin
					req_ff   <= 1'b0;
					state_ff <= coc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	assign mem_req_o      = req_ff;
	assign mem_we_o       = we_ff;
	assign mem_addr_o     = addr_ff;
	assign mem_size_o     = size_ff;
	assign mem_wdata_o    = wdata_ff;
	assign pc_o           = pc_ff;
	assign flags_o        = flags_ff;
	assign trap_o         = trap_ff;
	assign trap_vector_o  = trap_vector_ff;
	assign dbg_reg_data_o = dbg_ff;
endmodule
`default_nettype wire

// ===== coc_core_properties.sv
`timescale 1ns/1ps
`default_nettype none
module coc_core_chk (
	input wire logic               clk_sys_i,
	input wire logic               rst_n_i,
	input wire logic               ce_i,
	input wire logic               op_valid_i,
	input wire logic               op_ready_o,
	input wire coc_pkg::coc_op_t   op_code_i,
	input wire logic [4:0]         source_reg_field_i,
	input wire logic [2:0]         bit_number_i,
	input wire logic               bit_value_i,
	input wire logic [4:0]         trap_vector_i,
	input wire logic [3:0]         cond_code_i,
	input wire logic [8:0]         branch_displacement_i,
	input wire logic [15:0]        imm16_i,
	input wire coc_pkg::coc_size_t mem_size_i,
	input wire logic               mem_req_o,
	input wire logic               mem_we_o,
	input wire logic [31:0]        mem_addr_o,
	input wire coc_pkg::coc_size_t mem_size_o,
	input wire logic [31:0]        mem_wdata_o,
	input wire logic [31:0]        mem_rdata_i,
	input wire logic               mem_ack_i,
	input wire logic [31:0]        pc_o,
	input wire logic [4:0]         flags_o,
	input wire logic               trap_o,
	input wire logic [4:0]         trap_vector_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	wire       tk    = ce_i && op_valid_i && op_ready_o;
	wire [7:0] rbyte = mem_rdata_i[7:0];
	logic       bop_ff;
	logic [2:0] bnum_ff;
	logic       bval_ff;
	wire        rbit = mem_rdata_i[bnum_ff];
	wire        rdack = bop_ff && mem_req_o && !mem_we_o && mem_ack_i && ce_i;
	// remembers the bit operation in flight
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bop_ff  <= 1'b0;
			bnum_ff <= 3'h0;
			bval_ff <= 1'b0;
		end else if (tk) begin
			bop_ff  <= op_code_i == coc_pkg::OP_BIT_ST;
			bnum_ff <= bit_number_i;
			bval_ff <= bit_value_i;
		end
	end
	trap_vec_a: assert property (tk && op_code_i == coc_pkg::OP_TRAP |=> trap_o
		&& trap_vector_o == $past(trap_vector_i)) else $error("trap pulse or vector wrong");
	trap_pc_a: assert property (tk && op_code_i == coc_pkg::OP_TRAP |=> pc_o ==
		coc_pkg::TRAP_BASE + ({27'h0, $past(trap_vector_i)} << coc_pkg::VEC_SHIFT))
		else $error("trap target wrong");
	branch_pc_a: assert property (tk && op_code_i == coc_pkg::OP_BCOND
		&& cond_code_i == coc_pkg::CC_T |=> pc_o == $past(pc_o)
		+ 32'($signed($past(branch_displacement_i)))) else $error("branch target wrong");
	load_req_a: assert property (tk && op_code_i == coc_pkg::OP_LD
		&& source_reg_field_i == 5'h00 |=> mem_req_o && !mem_we_o
		&& mem_size_o == $past(mem_size_i) && mem_addr_o == 32'($signed($past(imm16_i))))
		else $error("load request wrong");
	req_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o
		&& $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o))
		else $error("memory request not held");
	busy_a: assert property (mem_req_o |-> !op_ready_o)
		else $error("ready while memory busy");
	bit_wr_a: assert property (rdack |=> mem_req_o && mem_we_o && $stable(mem_addr_o)
		&& mem_wdata_o[7:0] == (($past(rbyte) & ~(8'h01 << bnum_ff))
		| ({7'h00, bval_ff} << bnum_ff))) else $error("bit store data wrong");
	bit_z_a: assert property (rdack |=> flags_o[coc_pkg::FLG_Z] == !$past(rbit))
		else $error("bit store zero flag wrong");
endmodule
bind coc_core coc_core_chk coc_core_chk_inst (.clk_sys_i, .rst_n_i, .ce_i, .op_valid_i,
	.op_ready_o, .op_code_i, .source_reg_field_i, .bit_number_i, .bit_value_i, .trap_vector_i,
	.cond_code_i, .branch_displacement_i, .imm16_i, .mem_size_i, .mem_req_o, .mem_we_o,
	.mem_addr_o, .mem_size_o, .mem_wdata_o, .mem_rdata_i, .mem_ack_i, .pc_o, .flags_o,
	.trap_o, .trap_vector_o);
`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic op_valid_i = 1'b0;
	logic bit_value_i = 1'b0;
	logic mem_sign_i = 1'b0;
	logic mem_ack_i = 1'b0;
	logic [4:0] src_f = 5'h00, dst_f = 5'h00, aux_f = 5'h00, sys_f = 5'h00;
	logic [4:0] trap_vector_i = 5'h00, dbg_reg_idx_i = 5'h00;
	logic [2:0] bit_number_i = 3'h0;
	logic [3:0] cond_code_i = 4'h0;
	logic [8:0] branch_displacement_i = 9'h000;
	logic [15:0] imm16_i = 16'h0000;
	logic [31:0] mem_rdata_i = 32'h0, rd_word = 32'h0, wr_seen, ad_seen;
	coc_pkg::coc_op_t op_code_i = coc_pkg::OP_NOP;
	coc_pkg::coc_size_t mem_size_i = coc_pkg::SZ_WORD, mem_size_o;
	logic op_ready_o, mem_req_o, mem_we_o, trap_o;
	logic [31:0] mem_addr_o, mem_wdata_o, pc_o, dbg_reg_data_o;
	logic [4:0] flags_o, trap_vector_o;
	int lat = 0, wcnt = 0, cyc = 0, n_errors = 0, comparisons = 0;
	coc_core coc_core_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
		.op_valid_i(op_valid_i), .op_ready_o(op_ready_o), .op_code_i(op_code_i),
		.source_reg_field_i(src_f), .dest_reg_field_i(dst_f), .aux_result_reg_field_i(aux_f),
		.system_reg_number_i(sys_f), .bit_number_i(bit_number_i), .bit_value_i(bit_value_i),
		.trap_vector_i(trap_vector_i), .cond_code_i(cond_code_i),
		.branch_displacement_i(branch_displacement_i), .imm16_i(imm16_i),
		.mem_size_i(mem_size_i), .mem_sign_i(mem_sign_i), .instr_len_i(3'h4),
		.mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
		.mem_size_o(mem_size_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
		.mem_ack_i(mem_ack_i), .pc_o(pc_o), .flags_o(flags_o), .trap_o(trap_o),
		.trap_vector_o(trap_vector_o), .dbg_reg_idx_i(dbg_reg_idx_i),
		.dbg_reg_data_o(dbg_reg_data_o));
	initial forever #2.5 clk_sys_i = ~clk_sys_i;
	// memory responder, data line scrambled outside the ack cycle
	always @(posedge clk_sys_i) begin
		if (mem_ack_i) begin
			mem_ack_i <= 1'b0;
			mem_rdata_i <= ~mem_rdata_i;
		end else if (mem_req_o) begin
			if (wcnt >= lat) begin
				mem_ack_i <= 1'b1;
				mem_rdata_i <= rd_word;
				ad_seen <= mem_addr_o;
				wcnt <= 0;
				if (mem_we_o)
					wr_seen <= mem_wdata_o;
			end else
				wcnt <= wcnt + 1;
		end
	end
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_errors++;
			test_done();
		end
	end
	task test_done;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected at %0t: exp %h got %h", $time, e, g);
		end
	endtask
	task op(input coc_pkg::coc_op_t c, input logic [4:0] s, input logic [4:0] d,
		input logic [4:0] a, input logic [15:0] im);
		op_code_i <= c;
		src_f <= s;
		dst_f <= d;
		aux_f <= a;
		imm16_i <= im;
		op_valid_i <= 1'b1;
		@(posedge clk_sys_i);
		op_valid_i <= 1'b0;
		@(posedge clk_sys_i);
		while (op_ready_o !== 1'b1)
			@(posedge clk_sys_i);
	endtask
	task rd(input logic [4:0] r, input logic [31:0] e);
		dbg_reg_idx_i <= r;
		@(posedge clk_sys_i);
		@(posedge clk_sys_i);
		#1 chk(e, dbg_reg_data_o);
		@(posedge clk_sys_i);
	endtask
	task ld(input coc_pkg::coc_op_t c, input coc_pkg::coc_size_t z, input logic s,
		input logic [4:0] d, input logic [15:0] im, input logic [31:0] w, input logic [31:0] e);
		rd_word = w;
		mem_size_i <= z;
		mem_sign_i <= s;
		op(c, 5'h00, d, 5'h00, im);
		rd(d, e);
	endtask
	task t_ext;
		op(coc_pkg::OP_ADDI, 5'h00, 5'h05, 5'h00, 16'h8000);
		rd(5'h05, 32'hFFFF8000);
		op(coc_pkg::OP_ANDI, 5'h05, 5'h06, 5'h00, 16'hFFFF);
		rd(5'h06, 32'h00008000);
		op(coc_pkg::OP_ADDI, 5'h00, 5'h00, 5'h00, 16'h0005);
		rd(5'h00, 32'h00000000);
	endtask
	task t_branch;
		logic [31:0] p0;
		logic [15:0] taken;
		taken = 16'h53AC;
		op(coc_pkg::OP_ADD, 5'h00, 5'h10, 5'h00, 16'h0000);
		for (int c = 0; c < 16; c++) begin
			cond_code_i <= c[3:0];
			branch_displacement_i <= c[0] ? 9'h1F0 : 9'h0FC;
			p0 = pc_o;
			op(coc_pkg::OP_BCOND, 5'h00, 5'h00, 5'h00, 16'h0000);
			chk(p0 + (taken[c] ? (c[0] ? 32'hFFFFFFF0 : 32'hFC) : 32'h4), pc_o);
		end
	endtask
	task t_trap;
		logic [4:0] v[4] = '{5'h00, 5'h01, 5'h10, 5'h1F};
		foreach (v[i]) begin
			trap_vector_i <= v[i];
			op(coc_pkg::OP_TRAP, 5'h00, 5'h00, 5'h00, 16'h0000);
			chk(coc_pkg::TRAP_BASE + ({27'h0, v[i]} << coc_pkg::VEC_SHIFT), pc_o);
			chk({27'h0, v[i]}, {27'h0, trap_vector_o});
			chk(32'h1, 32'(trap_o));
		end
	endtask
	task t_load;
		lat = 3;
		ld(coc_pkg::OP_LD, coc_pkg::SZ_BYTE, 1'b0, 5'h08, 16'hFFF0, 32'h80F0, 32'hF0);
		ld(coc_pkg::OP_LD, coc_pkg::SZ_BYTE, 1'b1, 5'h08, 16'h0010, 32'h80F0, 32'hFFFFFFF0);
		ld(coc_pkg::OP_LD, coc_pkg::SZ_HALF, 1'b0, 5'h08, 16'h0012, 32'h80F0, 32'h80F0);
		ld(coc_pkg::OP_LD, coc_pkg::SZ_HALF, 1'b1, 5'h08, 16'h8000, 32'h80F0, 32'hFFFF80F0);
		ld(coc_pkg::OP_LD, coc_pkg::SZ_WORD, 1'b1, 5'h08, 16'h0020, 32'h80F0, 32'h80F0);
	endtask
	task t_sat;
		lat = 0;
		ld(coc_pkg::OP_LD, coc_pkg::SZ_WORD, 1'b0, 5'h01, 16'h0, 32'h7FFFFFFF, 32'h7FFFFFFF);
		op(coc_pkg::OP_ADDI, 5'h00, 5'h02, 5'h00, 16'h0001);
		op(coc_pkg::OP_SATADD, 5'h01, 5'h02, 5'h00, 16'h0000);
		rd(5'h02, 32'h7FFFFFFF);
		chk(32'h1, 32'(flags_o[coc_pkg::FLG_SAT]));
		ld(coc_pkg::OP_LD, coc_pkg::SZ_WORD, 1'b0, 5'h04, 16'h0, 32'h80000000, 32'h80000000);
		op(coc_pkg::OP_ADDI, 5'h00, 5'h07, 5'h00, 16'hFFFF);
		op(coc_pkg::OP_SATADD, 5'h04, 5'h07, 5'h00, 16'h0000);
		rd(5'h07, 32'h80000000);
	endtask
	task t_muldiv;
		ld(coc_pkg::OP_LD, coc_pkg::SZ_WORD, 1'b0, 5'h0A, 16'h0, 32'h7FFFFFFF, 32'h7FFFFFFF);
		op(coc_pkg::OP_ADDI, 5'h00, 5'h0B, 5'h00, 16'h0004);
		op(coc_pkg::OP_MUL, 5'h0B, 5'h0A, 5'h0C, 16'h0000);
		rd(5'h0A, 32'hFFFFFFFC);
		rd(5'h0C, 32'h00000001);
		op(coc_pkg::OP_ADDI, 5'h00, 5'h0D, 5'h00, 16'h7FFF);
		op(coc_pkg::OP_ADDI, 5'h00, 5'h0E, 5'h00, 16'h000A);
		op(coc_pkg::OP_DIV, 5'h0E, 5'h0D, 5'h0F, 16'h0000);
		rd(5'h0D, 32'h00000CCC);
		rd(5'h0F, 32'h00000007);
		op(coc_pkg::OP_DIV, 5'h00, 5'h0D, 5'h0F, 16'h0000);
		rd(5'h0D, 32'h00000CCC);
		chk(32'h1, 32'(flags_o[coc_pkg::FLG_OV]));
	endtask
	task t_bits;
		lat = 2;
		rd_word = 32'h000000A5;
		for (int b = 0; b < 8; b++) begin
			bit_number_i <= b[2:0];
			bit_value_i <= ~rd_word[b];
			op(coc_pkg::OP_BIT_ST, 5'h00, 5'h00, 5'h00, 16'h0020);
			chk({24'h0, rd_word[7:0] ^ (8'h01 << b)}, {24'h0, wr_seen[7:0]});
			chk(32'h20, ad_seen);
			chk(32'(!rd_word[b]), 32'(flags_o[coc_pkg::FLG_Z]));
		end
	endtask
	task t_ptr;
		op(coc_pkg::OP_ADDI, 5'h00, 5'h1E, 5'h00, 16'h0100);
		op(coc_pkg::OP_ADDI, 5'h00, 5'h03, 5'h00, 16'h0200);
		lat = 1;
		ld(coc_pkg::OP_LD_EP, coc_pkg::SZ_WORD, 1'b0, 5'h11, 16'h4, 32'hABCD, 32'hABCD);
		chk(32'h104, ad_seen);
		ld(coc_pkg::OP_LD_SP, coc_pkg::SZ_WORD, 1'b0, 5'h11, 16'h8, 32'h1234, 32'h1234);
		chk(32'h208, ad_seen);
		op(coc_pkg::OP_ST_EP, 5'h00, 5'h11, 5'h00, 16'h000C);
		chk(32'h10C, ad_seen);
		chk(32'h1234, wr_seen);
		op(coc_pkg::OP_ST, 5'h1E, 5'h10, 5'h00, 16'h0010);
		chk(32'h110, ad_seen);
		chk(32'h0, wr_seen);
		sys_f <= 5'h00;
		op(coc_pkg::OP_LDSR, 5'h1E, 5'h00, 5'h00, 16'h0000);
		sys_f <= 5'h01;
		op(coc_pkg::OP_LDSR, 5'h03, 5'h00, 5'h00, 16'h0000);
		op(coc_pkg::OP_STSR, 5'h00, 5'h13, 5'h00, 16'h0000);
		rd(5'h13, 32'h00000200);
		sys_f <= 5'h00;
		op(coc_pkg::OP_STSR, 5'h00, 5'h12, 5'h00, 16'h0000);
		rd(5'h12, 32'h00000100);
	endtask
	initial begin
		repeat (5) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		t_ext();
		t_branch();
		t_trap();
		t_load();
		t_sat();
		t_muldiv();
		t_bits();
		t_ptr();
		test_done();
	end
endmodule
`default_nettype wire
